//--- rtl/can_msg_if_data_status_view.sv
// register view of the message interface payload and 32-object summary vectors
// assumes a peripheral bus master that keeps the write and read spacing and reads twice
// assumes handler events and clears are one-cycle pulses on this same clock
`timescale 1ns/10ps
`include "can_view_cfg.svh"
module can_msg_if_data_status_view #(
    parameter int OBJECTS = 32,
    parameter int FETCH = `FETCH_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // peripheral bus slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    // message handler events, one-cycle pulses per object
    input wire logic [31:0] tx_request_set,
    input wire logic [31:0] tx_done,
    input wire logic [31:0] handler_new_data,
    input wire logic [31:0] object_irq_event,
    input wire logic [31:0] fresh_clear,
    input wire logic [31:0] irq_clear,
    input wire logic [31:0] in_use_set,
    input wire logic [31:0] in_use_clear,
    // state seen by the message handler
    output logic [31:0] tx_pending_bits,
    output logic [31:0] fresh_payload_bits,
    output logic [31:0] object_irq_pending,
    output logic [31:0] object_in_use
);
    // the register map fixes 32 objects; the fetch counter is eight bits wide
    initial begin
        if (OBJECTS != 32 || FETCH < 1) begin
            $error("view serves 32 objects and a fetch of at least one cycle");
        end
        if (FETCH > 256) begin
            $error("fetch counter holds at most 256 cycles");
        end
    end

    // halfword slot index in the payload store: interface bit and pair number
    // bit 3 marks a hit, so unmapped offsets never reach the store
    function automatic logic [3:0] payload_slot(input logic [11:0] a);
        logic [3:0] s;
        s = 4'h0;
        case (a)
            `IF1_BYTES_0_1: s = 4'h8;
            `IF1_BYTES_2_3: s = 4'h9;
            `IF1_BYTES_4_5: s = 4'ha;
            `IF1_BYTES_6_7: s = 4'hb;
            `IF2_BYTES_0_1: s = 4'hc;
            `IF2_BYTES_2_3: s = 4'hd;
            `IF2_BYTES_4_5: s = 4'he;
            `IF2_BYTES_6_7: s = 4'hf;
            default: s = 4'h0;
        endcase
        return s;
    endfunction

    // summary vector select: low half for objects 1..16, high for 17..32
    // bit 0 of a vector is object 1, so no offset is needed
    function automatic logic [15:0] summary_half(input logic [31:0] v, input logic hi);
        return hi ? v[31:16] : v[15:0];
    endfunction

    // bus phase decode; a write lands on its access edge with no wait state
    wire logic access = psel && penable;
    wire logic wr_access = access && pwrite;
    wire logic rd_access = access && !pwrite;
    wire logic rd_setup = psel && !penable && !pwrite;
    wire logic [3:0] wr_slot = payload_slot(paddr);
    wire logic wr_payload = wr_access && wr_slot[3];
    wire logic [15:0] store_q;

    can_view_pkg::fetch_state_t state;
    can_view_pkg::fetch_state_t next_state;
    logic [11:0] fetch_addr;
    logic [7:0] fetch_count;
    logic [31:0] fetch_data;

    // store slot of the latched address; bit 3 says the fetch targets payload
    wire logic [3:0] rd_slot = payload_slot(fetch_addr);
    wire logic start_fetch = (state == can_view_pkg::idle) && rd_access;
    wire logic fetch_done = (state == can_view_pkg::fetching) && (fetch_count == 8'(FETCH - 1));
    wire logic [7:0] next_fetch_count =
        (state == can_view_pkg::fetching) ? fetch_count + 8'h01 : 8'h00;

    // next flag values: a set landing with its clear wins, so no event is lost
    wire logic [31:0] next_tx_pending = (tx_pending_bits & ~tx_done) | tx_request_set;
    wire logic [31:0] next_fresh = (fresh_payload_bits & ~fresh_clear) | handler_new_data;
    wire logic [31:0] next_irq_pending = (object_irq_pending & ~irq_clear) | object_irq_event;
    wire logic [31:0] next_in_use = (object_in_use & ~in_use_clear) | in_use_set;

    // payload bytes in lane order, byte n of a pair in bits 7:0, n+1 in 15:8
    // whole halfwords only: the bus carries no byte strobes
    payload_store #(.ADDR_W(3)) u_payload_store (
        .clk(clk),
        .wr_en(wr_payload),
        .wr_addr(wr_slot[2:0]),
        .wr_data(pwdata[15:0]),
        .wr_lanes(2'b11),
        .rd_addr(rd_slot[2:0]),
        .rd_data(store_q)
    );

    // transmit pending: set by request, dropped once the frame went out
    // reading never clears a bit; only the handler's pulses move it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_pending_bits <= `SUMMARY_RESET;
        end else begin
            tx_pending_bits <= next_tx_pending;
        end
    end

    // fresh payload: sticky until the cpu clear pulse, set wins a tie
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fresh_payload_bits <= `SUMMARY_RESET;
        end else begin
            fresh_payload_bits <= next_fresh;
        end
    end

    // interrupt pending: sticky until the cpu clear pulse, set wins a tie
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            object_irq_pending <= `SUMMARY_RESET;
        end else begin
            object_irq_pending <= next_irq_pending;
        end
    end

    // in-use flags gate which objects the handler considers
    // a cleared object leaves the handler's scan on the next cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            object_in_use <= `SUMMARY_RESET;
        end else begin
            object_in_use <= next_in_use;
        end
    end

    // fetch sequencer: models the slow core handing a value across
    // a read to another register while ready drops the fetched value
    always_comb begin
        next_state = state;
        case (state)
            can_view_pkg::idle: begin
                if (rd_access) begin
                    next_state = can_view_pkg::fetching;
                end
            end
            can_view_pkg::fetching: begin
                if (fetch_done) begin
                    next_state = can_view_pkg::ready;
                end
            end
            can_view_pkg::ready: begin
                if (rd_access) begin
                    next_state = can_view_pkg::idle;
                end
            end
            default: next_state = can_view_pkg::idle;
        endcase
    end

    // summary decode on the latched address; bit 2 picks objects 17..32
    wire logic [8:0] fetch_row = fetch_addr[11:3];
    wire logic hi_half = fetch_addr[2];
    wire logic hit_tx = fetch_row == 9'(`TX_PENDING_LOW >> 3);
    wire logic hit_fresh = fetch_row == 9'(`FRESH_LOW >> 3);
    wire logic hit_irq = fetch_row == 9'(`IRQ_PEND_LOW >> 3);
    wire logic hit_use = fetch_row == 9'(`IN_USE_LOW >> 3);
    wire logic [15:0] summary_q =
        hit_tx ? summary_half(tx_pending_bits, hi_half) :
        hit_fresh ? summary_half(fresh_payload_bits, hi_half) :
        hit_irq ? summary_half(object_irq_pending, hi_half) :
        hit_use ? summary_half(object_in_use, hi_half) :
        16'h0000;
    wire logic fetch_is_payload = rd_slot[3];

    // sequencer state and latched address
    // the address is latched at the first read; the second must repeat it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= can_view_pkg::idle;
            fetch_addr <= 12'h000;
            fetch_count <= 8'h00;
        end else begin
            state <= next_state;
            if (start_fetch) begin
                fetch_addr <= paddr;
            end
            fetch_count <= next_fetch_count;
        end
    end

    // value captured at the end of the fetch, held for the second read
    // captured once, so a flag moving between the reads cannot tear the value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_data <= 32'h0000_0000;
        end else if (fetch_done) begin
            fetch_data <= {16'h0000, fetch_is_payload ? store_q : summary_q};
        end
    end

    // read data: first read gives zero, second read the fetched one
    // a pair to two different addresses reads zero rather than a wrong register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= (state == can_view_pkg::ready && paddr == fetch_addr) ?
                fetch_data : 32'h0000_0000;
        end
    end
endmodule // can_msg_if_data_status_view

//--- rtl/can_view_cfg.svh
// register offsets, field positions and timing counts of the message interface view
// assumes byte addresses on the peripheral bus, 16-bit data in the low half of each word
// Contract
// - first data register holds payload byte 0 in bits 7:0, byte 1 in 15:8, read/write.
// - second data register holds payload byte 2 low, byte 3 high, read/write.
// - third and fourth data registers hold bytes 4,5 then 6,7, lower byte low.
// - read-only transmit pending bit per object, one while transmission requested, not done.
// - read-only fresh payload bit per object, set by new data, held until CPU clears.
// - read-only interrupt pending bit per object, set by interrupt, held until CPU clears.
// - read-only in-use bit per object; handler processes only objects with bit set. The view sets tx pending, fresh and interrupt bits whatever the in-use bit is.
`ifndef CAN_VIEW_CFG_SVH
`define CAN_VIEW_CFG_SVH

`define IF1_BYTES_0_1 12'h03c
`define IF1_BYTES_2_3 12'h040
`define IF1_BYTES_4_5 12'h044
`define IF1_BYTES_6_7 12'h048
`define IF2_BYTES_0_1 12'h09c
`define IF2_BYTES_2_3 12'h0a0
`define IF2_BYTES_4_5 12'h0a4
`define IF2_BYTES_6_7 12'h0a8
`define TX_PENDING_LOW 12'h100
`define TX_PENDING_HIGH 12'h104
`define FRESH_LOW 12'h120
`define FRESH_HIGH 12'h124
`define IRQ_PEND_LOW 12'h140
`define IRQ_PEND_HIGH 12'h144
`define IN_USE_LOW 12'h160
`define IN_USE_HIGH 12'h164

`define LOW_BYTE_LSB 0
`define HIGH_BYTE_LSB 8
`define PAYLOAD_RESET 16'h0000
`define SUMMARY_RESET 32'h0000_0000

// core latency of one fetch, in bus clocks: two core clocks at six bus clocks each
`define CORE_CLK_RATIO 6
`define FETCH_CYCLES (2 * `CORE_CLK_RATIO)

`endif

//--- rtl/can_view_pkg.sv
// types shared by the message interface view
// assumes the constants header is included where offsets are needed
package can_view_pkg;
    typedef enum logic [1:0] {idle, fetching, ready} fetch_state_t;
    typedef logic [15:0] half_word_t;
endpackage

//--- rtl/payload_store.sv
// eight-entry payload memory: two interfaces by four halfwords
// assumes one clock; read data is registered one cycle after the address
`timescale 1ns/10ps
module payload_store #(
    parameter int ADDR_W = 3
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_lanes,
    // read side
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [0:(1<<ADDR_W)-1];

    initial begin
        if (ADDR_W < 3) begin
            $error("payload_store needs eight halfwords");
        end
    end

    // byte lanes keep a half write from touching the other byte
    always_ff @(posedge clk) begin
        if (wr_en && wr_lanes[0]) begin
            mem[wr_addr][7:0] <= wr_data[7:0];
        end
        if (wr_en && wr_lanes[1]) begin
            mem[wr_addr][15:8] <= wr_data[15:8];
        end
        rd_data <= mem[rd_addr];
    end
endmodule // payload_store

//--- test/can_view_props.sv
// assertions on the message interface view ports
// assumes it is bound to the view's top module, one clock domain
`timescale 1ns/10ps
module can_view_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    // handler events
    input wire logic [31:0] tx_request_set,
    input wire logic [31:0] tx_done,
    input wire logic [31:0] handler_new_data,
    input wire logic [31:0] object_irq_event,
    input wire logic [31:0] fresh_clear,
    input wire logic [31:0] irq_clear,
    input wire logic [31:0] in_use_set,
    input wire logic [31:0] in_use_clear,
    // flags
    input wire logic [31:0] tx_pending_bits,
    input wire logic [31:0] fresh_payload_bits,
    input wire logic [31:0] object_irq_pending,
    input wire logic [31:0] object_in_use
);
    // a clear only counts where no set lands in the same cycle, since set wins
    wire logic [31:0] tx_clr = tx_done & ~tx_request_set;
    wire logic [31:0] use_clr = in_use_clear & ~in_use_set;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_no_rd_setup;
        !(psel && !penable && !pwrite);
    endsequence
    property p_prdata_hold; s_no_rd_setup |=> $stable(prdata); endproperty
    property p_tx_set; (tx_request_set != 32'h0) |=>
        (tx_pending_bits & $past(tx_request_set)) == $past(tx_request_set); endproperty
    property p_tx_clear; (tx_clr != 32'h0) |=> (tx_pending_bits & $past(tx_clr)) == 32'h0;
    endproperty
    property p_fresh_set; (handler_new_data != 32'h0) |=>
        (fresh_payload_bits & $past(handler_new_data)) == $past(handler_new_data); endproperty
    property p_fresh_hold; 1'b1 |=>
        (~fresh_payload_bits & $past(fresh_payload_bits) & ~$past(fresh_clear)) == 32'h0;
    endproperty
    property p_irq_set; (object_irq_event != 32'h0) |=>
        (object_irq_pending & $past(object_irq_event)) == $past(object_irq_event); endproperty
    property p_irq_hold; 1'b1 |=>
        (~object_irq_pending & $past(object_irq_pending) & ~$past(irq_clear)) == 32'h0;
    endproperty
    property p_use_set; (in_use_set != 32'h0) |=>
        (object_in_use & $past(in_use_set)) == $past(in_use_set); endproperty
    property p_use_clear; (use_clr != 32'h0) |=> (object_in_use & $past(use_clr)) == 32'h0;
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");
    a_tx_set: assert property (p_tx_set) else $error("tx pending not set");
    a_tx_clear: assert property (p_tx_clear) else $error("tx pending not cleared");
    a_fresh_set: assert property (p_fresh_set) else $error("fresh bit not set");
    a_fresh_hold: assert property (p_fresh_hold) else $error("fresh bit dropped");
    a_irq_set: assert property (p_irq_set) else $error("irq bit not set");
    a_irq_hold: assert property (p_irq_hold) else $error("irq bit dropped");
    a_use_set: assert property (p_use_set) else $error("in use not set");
    a_use_clear: assert property (p_use_clear) else $error("in use not cleared");
endmodule // can_view_props

//--- test/can_apb_master.sv
// bus master model for the message interface view
// assumes the view samples on the rising edge; this model drives on the falling edge
`timescale 1ns/10ps
module can_apb_master (
    // clock
    input wire logic clk,
    // bus
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // setup then access; released address and data lines show inverted values, not stale ones
    task xfer(input logic w, input logic [11:0] a, input logic [15:0] v);
        @(negedge clk);
        {psel, pwrite, paddr, pwdata} = {1'b1, w, a, 16'h0000, v};
        @(negedge clk);
        penable = 1'b1;
        @(negedge clk);
        {psel, penable, paddr, pwdata} = {2'b00, ~a, ~pwdata};
    endtask
    task wr(input logic [11:0] a, input logic [15:0] v);
        xfer(1'b1, a, v);
        repeat (12) @(negedge clk);
    endtask
    // first read only launches the core fetch, second one carries the value
    task rd(input logic [11:0] a, output logic [15:0] v);
        xfer(1'b0, a, 16'h0000);
        repeat (13) @(negedge clk);
        xfer(1'b0, a, 16'h0000);
        v = prdata[15:0];
        repeat (13) @(negedge clk);
    endtask
endmodule // can_apb_master

//--- test/test_can_msg_if_data_status_view.sv
// self-checking bench for the message interface view
// assumes the master model owns the bus and the bench owns the handler events
`timescale 1ns/10ps
`include "can_view_cfg.svh"
module test_can_msg_if_data_status_view;
    logic clk, reset_n, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [31:0] tx_request_set, tx_done, handler_new_data, object_irq_event;
    logic [31:0] fresh_clear, irq_clear, in_use_set, in_use_clear;
    logic [31:0] tx_pending_bits, fresh_payload_bits, object_irq_pending, object_in_use;
    logic [15:0] d;
    int miscompares, checks_done, cycles;
    can_msg_if_data_status_view u_can_msg_if_data_status_view (.clk, .reset_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .tx_request_set, .tx_done, .handler_new_data,
        .object_irq_event, .fresh_clear, .irq_clear, .in_use_set, .in_use_clear,
        .tx_pending_bits, .fresh_payload_bits, .object_irq_pending, .object_in_use);
    can_apb_master u_can_apb_master (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one-cycle event pulse on every handler input at once
    task pulse(input logic [31:0] ts, td, nd, ie, fc, ic, us, uc);
        @(negedge clk);
        {tx_request_set, tx_done, handler_new_data, object_irq_event} = {ts, td, nd, ie};
        {fresh_clear, irq_clear, in_use_set, in_use_clear} = {fc, ic, us, uc};
        @(negedge clk);
        {tx_request_set, tx_done, handler_new_data, object_irq_event} = '0;
        {fresh_clear, irq_clear, in_use_set, in_use_clear} = '0;
    endtask
    function automatic logic [11:0] pay_addr(int i);
        return (i < 4 ? `IF1_BYTES_0_1 : `IF2_BYTES_0_1) + 12'(4 * (i % 4));
    endfunction
    // all eight written before any read, so the two interfaces must not alias
    task payload_test;
        for (int i = 0; i < 8; i++) begin
            u_can_apb_master.wr(pay_addr(i), 16'h9060 + 16'(i) * 16'h0101);
        end
        for (int i = 0; i < 8; i++) begin
            u_can_apb_master.rd(pay_addr(i), d);
            chk({16'h0000, d}, {16'h0000, 16'h9060 + 16'(i) * 16'h0101});
        end
    endtask
    // second pulse clears some bits and sets fresh bit 0 against its own clear
    task summary_test;
        logic [11:0] offs [4];
        logic [31:0] exp [4];
        offs = '{`TX_PENDING_LOW, `FRESH_LOW, `IRQ_PEND_LOW, `IN_USE_LOW};
        exp = '{32'h8001_0001, 32'h4002_0001, 32'h2000_4001, 32'h0008_2001};
        pulse(32'h8001_0003, 32'h0, 32'h4002_8001, 32'h2004_4001,
            32'h0, 32'h0, 32'h1008_2001, 32'h0);
        pulse(32'h0, 32'h2, 32'h1, 32'h0,
            32'h0000_8001, 32'h0004_0000, 32'h0, 32'h1000_0000);
        repeat (20) @(negedge clk);
        chk(tx_pending_bits, exp[0]);
        chk(fresh_payload_bits, exp[1]);
        chk(object_irq_pending, exp[2]);
        chk(object_in_use, exp[3]);
        for (int i = 0; i < 4; i++) begin
            u_can_apb_master.rd(offs[i], d);
            chk({16'h0000, d}, {16'h0000, exp[i][15:0]});
            u_can_apb_master.rd(offs[i] + 12'h004, d);
            chk({16'h0000, d}, {16'h0000, exp[i][31:16]});
        end
    endtask
    // first read of a pair shows zero, the second the fetched value; unmapped reads zero
    task pairing_test;
        u_can_apb_master.xfer(1'b0, `FRESH_LOW, 16'h0000);
        chk(prdata, 32'h0000_0000);
        repeat (13) @(negedge clk);
        u_can_apb_master.xfer(1'b0, `FRESH_LOW, 16'h0000);
        chk(prdata, 32'h0000_0001);
        repeat (13) @(negedge clk);
        u_can_apb_master.rd(12'h1f0, d);
        chk({16'h0000, d}, 32'h0000_0000);
    endtask
    // ceiling well above the roughly 720 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        {tx_request_set, tx_done, handler_new_data, object_irq_event} = '0;
        {fresh_clear, irq_clear, in_use_set, in_use_clear} = '0;
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        payload_test();
        summary_test();
        pairing_test();
        test_done();
    end
endmodule // test_can_msg_if_data_status_view
bind can_msg_if_data_status_view can_view_props u_can_view_props (.clk, .reset_n, .psel,
    .penable, .pwrite, .prdata, .tx_request_set, .tx_done, .handler_new_data, .object_irq_event,
    .fresh_clear, .irq_clear, .in_use_set, .in_use_clear, .tx_pending_bits,
    .fresh_payload_bits, .object_irq_pending, .object_in_use);
